// ===== bench/grc_regs_bench.sv
/*
 Self-checking bench for the pin, rotation and frame timing bank.
 Assumes the classic Wishbone slave answers once per request.
*/
`timescale 1ns/1ps
module grc_regs_bench;
   import grc_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic               clk       = 1'b0; // 200 MHz clock
   logic               rst_n     = 1'b0; // Active low reset
   logic               cyc       = 1'b0;
   logic               stb       = 1'b0;
   logic               we        = 1'b0;
   logic [9:0]         adr       = 10'h000;
   logic [3:0]         sel       = 4'h0;
   logic [31:0]        wdat      = 32'h0;
   logic [31:0]        rdat;
   logic               ack;
   logic [NUM_PINS-1:0] pin_in   = 5'h00; // Far side pin levels
   logic [NUM_PINS-1:0] pin_out;
   logic [NUM_PINS-1:0] pin_oe;
   logic [NUM_DED-1:0] panel_up  = 4'h9;
   logic               pix_en, mem_en, rot_en, rot_var;
   logic               line_st, frame_st, disp_act;
   logic [15:0]        line_addr;
   int                 error_cnt = 0;
   int                 cmp_count = 0;

   grc_regs i_dut (.i_ref_clk(clk), .i_resetn(rst_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe),
      .i_panel_data_upper(panel_up), .o_pix_clk_en(pix_en),
      .o_mem_clk_en(mem_en), .o_rotation_enable(rot_en),
      .o_rotation_variant(rot_var), .o_line_start(line_st),
      .o_frame_start(frame_st), .o_display_active(disp_act),
      .o_line_addr(line_addr));

   // ==========================================================
   // Clock and watchdog
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // Whole run needs well under 10k cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask : chk

   // One classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= 4'hF;
      adr  <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      q = rdat[7:0];
      if (n >= 50)
         chk(32'h0, 32'h1, "ack wait");
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e,
                         input string what);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk({24'h0, q}, {24'h0, e}, what);
   endtask : rd_chk

   // Cycles until a line (f=0) or frame (f=1) pulse, bounded
   task automatic wait_pulse(input bit f, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while ((f ? frame_st : line_st) !== 1'b1 && n < 2000);
   endtask : wait_pulse

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rd_chk(IDX_SCR, RST_BYTE, "scratch reset");
      rd_chk(IDX_ROT, RST_BYTE, "rotation reset");
      wr(IDX_SCR, 8'hA5);
      rd_chk(IDX_SCR, 8'hA5, "scratch");
      chk(pin_oe, 5'h00, "scratch side effect");
      wr(IDX_STRIDE, 8'h5A);
      rd_chk(IDX_STRIDE, 8'h5A, "stride");
      wr(IDX_PDIR, 8'hE0);
      rd_chk(IDX_PDIR, 8'h00, "dir upper bits");
      wr(8'h1D, 8'hFF);
      rd_chk(8'h1D, 8'h00, "unmapped read");
   endtask : t_regs

   task automatic t_pins();
      pin_in <= 5'h0C;
      wr(IDX_PDIR, 8'h03);
      wr(IDX_PLVL, 8'h15);
      repeat (4) @(posedge clk);
      chk(pin_oe, 5'h03, "mixed oe");
      chk(pin_out[1:0], 2'b01, "driven level");
      rd_chk(IDX_PLVL, 8'h0D, "mixed level read");
      wr(IDX_PDIR, 8'h1F);
      wr(IDX_PLVL, 8'hEA);
      @(posedge clk);
      chk(pin_out, 5'h0A, "output level");
      chk(pin_oe, 5'h1F, "all out");
      rd_chk(IDX_PLVL, 8'h0A, "level upper bits");
      wr(IDX_PDIR, 8'h00);
      @(posedge clk);
      chk(pin_oe, 5'h00, "all in");
      rd_chk(IDX_PLVL, 8'h0C, "all in read");
      wr(IDX_PANEL, 8'h01);
      @(posedge clk);
      chk(pin_oe, 5'h0F, "dedicated oe");
      chk(pin_out[3:0], panel_up, "dedicated data");
      wr(IDX_PDIR, 8'h1F);
      panel_up <= 4'h6;
      @(posedge clk);
      @(posedge clk);
      chk(pin_out[3:0], 4'h6, "dir ignored");
      wr(IDX_PANEL, 8'h00);
   endtask : t_pins

   // Ticks seen in 64 cycles against a divisor per clock
   task automatic ticks(input int pd, input int md, input string what);
      int p, m;
      p = 0;
      m = 0;
      repeat (64)
      begin
         @(posedge clk);
         if (pix_en === 1'b1) p++;
         if (mem_en === 1'b1) m++;
      end
      chk(p, 64 / pd, what);
      chk(m, 64 / md, what);
   endtask : ticks

   task automatic t_clocks();
      int pd, md;
      wr(IDX_CLKCFG, 8'h20);
      wr(IDX_ROT, 8'h03);
      chk({rot_en, rot_var}, 2'b00, "landscape");
      ticks(1, 2, "landscape clocks");
      for (int h = 0; h < 2; h++)
         for (int v = 0; v < 2; v++)
            for (int s = 0; s < 4; s++)
            begin
               wr(IDX_CLKCFG, h ? 8'h10 : 8'h00);
               wr(IDX_ROT, {1'b1, v[0], 4'h0, s[1:0]});
               chk({rot_en, rot_var}, {1'b1, v[0]}, "variant");
               pd = v ? ((s == 0) ? 2 : (1 << s)) : (1 << s);
               md = v ? ((s < 2) ? 1 : (1 << (s - 1))) : (1 << s);
               ticks(pd << h, md << h, "rotated clocks");
            end
   endtask : t_clocks

   task automatic t_frame();
      int n;
      wr(IDX_CLKCFG, 8'h00);
      wr(IDX_HWIDTH, 8'h81);
      wr(IDX_HBLANK, 8'hE1);
      wr(IDX_VHLO, 8'h02);
      wr(IDX_VHHI, 8'h00);
      wr(IDX_VBLANK, 8'hC1);
      wr(IDX_STRIDE, 8'h10);
      wr(IDX_ROT, 8'h80);
      wait_pulse(1'b0, n);
      wait_pulse(1'b0, n);
      chk(n, 56, "line length");
      wait_pulse(1'b1, n);
      wait_pulse(1'b1, n);
      chk(n, 224, "frame length");
      repeat (2) @(posedge clk);
      chk(line_addr, 16'h0000, "addr at frame");
      chk(disp_act, 1'b1, "active at frame");
      wait_pulse(1'b0, n);
      repeat (2) @(posedge clk);
      chk(line_addr, 16'h0010, "addr stride");
      // Pixel 21 of the line lies past the 16 display pixels
      repeat (20) @(posedge clk);
      chk(disp_act, 1'b0, "horizontal blank");
   endtask : t_frame

   // ==========================================================
   // Closing and main sequence
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_pins();
      t_clocks();
      t_frame();
      end_of_test();
   end
endmodule : grc_regs_bench

// ===== rtl/grc_pkg.sv
/*
 Register offsets, field positions, reset values and carrier types for
 the pin, rotation and frame timing register bank. Assumes a 32-bit
 classic Wishbone bus with one aligned word per register.
*/
package grc_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_PANEL  = 8'h01; // Panel mode
   localparam logic [7:0] IDX_CLKCFG = 8'h02; // Clock configuration
   localparam logic [7:0] IDX_HWIDTH = 8'h04; // Horizontal width
   localparam logic [7:0] IDX_VHLO   = 8'h05; // Height low byte
   localparam logic [7:0] IDX_VHHI   = 8'h06; // Height high bits
   localparam logic [7:0] IDX_HBLANK = 8'h08; // Horizontal blanking
   localparam logic [7:0] IDX_VBLANK = 8'h0A; // Vertical blanking
   localparam logic [7:0] IDX_PDIR   = 8'h18; // pin_direction
   localparam logic [7:0] IDX_PLVL   = 8'h19; // pin_level_control
   localparam logic [7:0] IDX_SCR    = 8'h1A; // scratch_pad
   localparam logic [7:0] IDX_ROT    = 8'h1B; // rotation_mode
   localparam logic [7:0] IDX_STRIDE = 8'h1C; // rotated_line_stride
   localparam logic [7:0] IDX_FTA    = 8'h1E; // factory_test_a
   localparam logic [7:0] IDX_FTB    = 8'h1F; // factory_test_b
   // ==========================================================
   // Field positions
   localparam int POS_ROT_EN  = 7; // rotation_enable
   localparam int POS_ROT_VAR = 6; // rotation_variant_select
   localparam int POS_HALVE   = 4; // Root clock is input halved
   localparam int POS_MCLKDIV = 5; // Landscape memory clock halved
   localparam int NUM_PINS    = 5; // General purpose pins
   localparam int NUM_DED     = 4; // Pins shared with panel data
   // ==========================================================
   // Reset values and timing offsets
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [10:0] HDP_ADD  = 11'h001; // Width plus one
   localparam logic [10:0] HORIZ_BLANK_PERIOD_ADD = 11'h004; // Blanking plus four
   localparam logic [10:0] VDP_ADD  = 11'h001; // Height plus one
   localparam int          PIX_SHIFT = 3;      // Eight pixels a unit
   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic [NUM_PINS-1:0] lvl; // Driven level
      logic [NUM_PINS-1:0] oe;  // Output enable
   } grc_pins_t;
   typedef struct packed {
      logic [3:0] pix_mask; // Pixel clock tick mask
      logic [3:0] mem_mask; // Memory clock tick mask
   } grc_clk_t;
endpackage : grc_pkg

// ===== rtl/grc_regs.sv
/*
 Pin, rotation and frame timing register bank with a Wishbone slave,
 clock tick generation and frame counters. Assumes one clock, a
 synchronous active low reset and pins resolved outside this module.
*/
// Register access over Wishbone was chosen for this implementation.
// ==========================================================
// Summary of operation
// - Direction zero makes the pin an undriven input
// - Direction one drives pin from control bit
// - Dedicated panel pins ignore direction bits
// - Input pins read back their sampled level
// - Written control bit sets the driven output level
// - Scratch byte stores values, affects nothing
// - Bit 7 enables rotation, else landscape
// - Bit 6 picks default or alternate variant
// - Landscape: pixel at root, memory per bit 5
// - Default variant divides both clocks 1,2,4,8
// - Alternate variant: pixel slower than memory clock
// - Stride byte spaces rotated line start addresses
// - Frame is total pixels times total lines
// - Display width is field plus one, times eight
// - Blank width is field plus four, times eight
// - Display height is ten-bit field plus one
// - Vertical blank is the six-bit field
`timescale 1ns/1ps
module grc_regs
   import grc_pkg::*;
(
   input  wire logic                i_ref_clk,
   input  wire logic                i_resetn,
   input  wire logic                i_wb_cyc,
   input  wire logic                i_wb_stb,
   input  wire logic                i_wb_we,
   input  wire logic [9:0]          i_wb_adr,
   input  wire logic [3:0]          i_wb_sel,
   input  wire logic [31:0]         i_wb_dat,
   output logic      [31:0]         o_wb_dat,
   output logic                     o_wb_ack,
   input  wire logic [NUM_PINS-1:0] i_pin,
   output logic      [NUM_PINS-1:0] o_pin,
   output logic      [NUM_PINS-1:0] o_pin_oe,
   input  wire logic [NUM_DED-1:0]  i_panel_data_upper,
   output logic                     o_pix_clk_en,
   output logic                     o_mem_clk_en,
   output logic                     o_rotation_enable,
   output logic                     o_rotation_variant,
   output logic                     o_line_start,
   output logic                     o_frame_start,
   output logic                     o_display_active,
   output logic      [15:0]         o_line_addr
);
   // ==========================================================
   // Register state
   logic [7:0]          panel_ff;  // Bit 0: active matrix panel
   logic [7:0]          clkcfg_ff; // Root halve and memory clock
   logic [6:0]          hw_ff;     // Horizontal width field
   logic [7:0]          vhlo_ff;   // Height low byte
   logic [1:0]          vhhi_ff;   // Height high bits
   logic [4:0]          hb_ff;     // Horizontal blanking field
   logic [5:0]          vb_ff;     // Vertical blanking field
   logic [NUM_PINS-1:0] dir_ff;    // Pin directions
   logic [NUM_PINS-1:0] ctl_ff;    // Pin control levels
   logic [7:0]          scr_ff;    // Scratch byte
   logic [7:0]          rot_ff;    // Rotation mode
   logic [7:0]          stride_ff; // Rotated line stride
   logic [NUM_PINS-1:0] sync1_ff;  // Pin synchroniser, first stage
   logic [NUM_PINS-1:0] sync2_ff;  // Pin synchroniser, second stage
   logic                ack_ff;    // Bus acknowledge
   logic [31:0]         dat_ff;    // Bus read data
   logic [7:0]          idx;       // Register index of the access
   logic                req;       // New bus request this cycle
   logic                wr;        // Write with low byte lane
   logic [7:0]          wdat;      // Written byte
   logic [7:0]          nxt_rdat;  // Read byte for the index
   logic [NUM_PINS-1:0] ded;       // Pins held by the panel
   logic [NUM_PINS-1:0] pin_view;  // Level seen by a read
   grc_pins_t           pins;      // Resolved pin drive

   assign idx  = i_wb_adr[9:2];
   assign req  = i_wb_cyc & i_wb_stb & ~ack_ff;
   assign wr   = req & i_wb_we & i_wb_sel[0];
   assign wdat = i_wb_dat[7:0];

   // ==========================================================
   // Register writes; factory test and unmapped writes dropped
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         panel_ff  <= RST_BYTE;
         clkcfg_ff <= RST_BYTE;
         hw_ff     <= 7'h00;
         vhlo_ff   <= RST_BYTE;
         vhhi_ff   <= 2'h0;
         hb_ff     <= 5'h00;
         vb_ff     <= 6'h00;
         dir_ff    <= 5'h00;
         ctl_ff    <= 5'h00;
         scr_ff    <= RST_BYTE;
         rot_ff    <= RST_BYTE;
         stride_ff <= RST_BYTE;
      end
      else if (wr)
      begin
         case (idx)
            IDX_PANEL:  panel_ff  <= wdat;
            IDX_CLKCFG: clkcfg_ff <= wdat;
            IDX_HWIDTH: hw_ff     <= wdat[6:0];
            IDX_VHLO:   vhlo_ff   <= wdat;
            IDX_VHHI:   vhhi_ff   <= wdat[1:0];
            IDX_HBLANK: hb_ff     <= wdat[4:0];
            IDX_VBLANK: vb_ff     <= wdat[5:0];
            IDX_PDIR:   dir_ff    <= wdat[4:0];
            IDX_PLVL:   ctl_ff    <= wdat[4:0];
            IDX_SCR:    scr_ff    <= wdat;
            // Bit 2 kept as written; host must keep it zero
            IDX_ROT:    rot_ff    <= wdat;
            IDX_STRIDE: stride_ff <= wdat;
            default:    ; // Factory test locations store nothing
         endcase
      end
   end

   // ==========================================================
   // Pin synchroniser; only the second stage is read
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
      end
      else
      begin
         sync1_ff <= i_pin;
         sync2_ff <= sync1_ff;
      end
   end

   // ==========================================================
   // Pin drive; panel data overrides direction on shared pins
   assign ded = {1'b0, {NUM_DED{panel_ff[0]}}};
   always_comb
   begin
      pins.oe  = dir_ff | ded;
      pins.lvl = ctl_ff;
      if (panel_ff[0])
      begin
         pins.lvl[NUM_DED-1:0] = i_panel_data_upper;
      end
   end
   assign o_pin    = pins.lvl;
   assign o_pin_oe = pins.oe;
   // Inputs show the pin, outputs the written bit
   assign pin_view = (dir_ff & ctl_ff) | (~dir_ff & sync2_ff);

   // ==========================================================
   // Read decode; unmapped and factory locations read zero
   always_comb
   begin
      case (idx)
         IDX_PANEL:  nxt_rdat = panel_ff;
         IDX_CLKCFG: nxt_rdat = clkcfg_ff;
         IDX_HWIDTH: nxt_rdat = {1'b0, hw_ff};
         IDX_VHLO:   nxt_rdat = vhlo_ff;
         IDX_VHHI:   nxt_rdat = {6'h00, vhhi_ff};
         IDX_HBLANK: nxt_rdat = {3'h0, hb_ff};
         IDX_VBLANK: nxt_rdat = {2'h0, vb_ff};
         IDX_PDIR:   nxt_rdat = {3'h0, dir_ff};
         IDX_PLVL:   nxt_rdat = {3'h0, pin_view};
         IDX_SCR:    nxt_rdat = scr_ff;
         IDX_ROT:    nxt_rdat = rot_ff;
         IDX_STRIDE: nxt_rdat = stride_ff;
         default:    nxt_rdat = RST_BYTE;
      endcase
   end

   // ==========================================================
   // Bus answer one cycle after the request, dropped after
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= req;
         if (req)
         begin
            dat_ff <= {24'h00_0000, nxt_rdat};
         end
      end
   end
   assign o_wb_ack = ack_ff;
   assign o_wb_dat = dat_ff;

   // ==========================================================
   // Clock tick masks from mode; ticks are enables, not clocks
   grc_clk_t      cm;     // Selected masks
   logic [1:0]    csel;   // Divisor select
   logic [3:0]    sh;     // Root tick mask
   logic [3:0]    div_ff; // Free running divider
   assign csel = rot_ff[1:0];
   // Root is one or two input cycles
   assign sh = clkcfg_ff[POS_HALVE] ? 4'h1 : 4'h0;
   always_comb
   begin
      cm.pix_mask = sh;
      cm.mem_mask = clkcfg_ff[POS_MCLKDIV] ? {sh[2:0], 1'b1} : sh;
      if (rot_ff[POS_ROT_EN])
      begin
         if (!rot_ff[POS_ROT_VAR])
         begin
            case (csel)
               2'h0:    cm.pix_mask = sh;
               2'h1:    cm.pix_mask = {sh[2:0], 1'b1};
               2'h2:    cm.pix_mask = {sh[1:0], 2'h3};
               default: cm.pix_mask = {sh[0], 3'h7};
            endcase
            cm.mem_mask = cm.pix_mask;
         end
         else
         begin
            case (csel)
               2'h0, 2'h1:
               begin
                  cm.pix_mask = {sh[2:0], 1'b1};
                  cm.mem_mask = sh;
               end
               2'h2:
               begin
                  cm.pix_mask = {sh[1:0], 2'h3};
                  cm.mem_mask = {sh[2:0], 1'b1};
               end
               default:
               begin
                  cm.pix_mask = {sh[0], 3'h7};
                  cm.mem_mask = {sh[1:0], 2'h3};
               end
            endcase
         end
      end
   end

   // Divider count; nested masks keep both ticks aligned
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         div_ff <= 4'h0;
      end
      else
      begin
         div_ff <= div_ff + 4'h1;
      end
   end
   assign o_pix_clk_en = (div_ff & cm.pix_mask) == cm.pix_mask;
   assign o_mem_clk_en = (div_ff & cm.mem_mask) == cm.mem_mask;
   assign o_rotation_enable  = rot_ff[POS_ROT_EN];
   assign o_rotation_variant = rot_ff[POS_ROT_EN] & rot_ff[POS_ROT_VAR];

   // ==========================================================
   // Frame timing totals in pixel clocks and lines
   logic [10:0] horiz_display_period;    // Display pixels
   logic [10:0] htot;   // Pixels per line
   logic [10:0] vert_display_period;    // Display lines
   logic [10:0] vtot;   // Lines per frame
   logic [10:0] x_ff;   // Pixel position
   logic [10:0] y_ff;   // Line position
   logic        ls_ff;  // Line start pulse
   logic        fs_ff;  // Frame start pulse
   logic        act_ff; // Inside display area
   logic [15:0] addr_ff;// Line start address
   logic        eol;    // Last pixel of line
   logic        eof;    // Last line of frame
   assign horiz_display_period  = ({4'h0, hw_ff} + HDP_ADD) << PIX_SHIFT;
   assign htot = horiz_display_period + (({6'h00, hb_ff} + HORIZ_BLANK_PERIOD_ADD) << PIX_SHIFT);
   assign vert_display_period  = {1'b0, vhhi_ff, vhlo_ff} + VDP_ADD;
   assign vtot = vert_display_period + {5'h00, vb_ff};
   assign eol  = x_ff >= htot - 11'h001;
   assign eof  = y_ff >= vtot - 11'h001;

   // Frame counters advance on pixel ticks only
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         x_ff  <= 11'h000;
         y_ff  <= 11'h000;
         ls_ff <= 1'b0;
         fs_ff <= 1'b0;
      end
      else
      begin
         ls_ff <= o_pix_clk_en & eol;
         fs_ff <= o_pix_clk_en & eol & eof;
         if (o_pix_clk_en)
         begin
            x_ff <= eol ? 11'h000 : x_ff + 11'h001;
            if (eol)
            begin
               y_ff <= eof ? 11'h000 : y_ff + 11'h001;
            end
         end
      end
   end

   // Display window flag and rotated line address
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         act_ff  <= 1'b0;
         addr_ff <= 16'h0000;
      end
      else
      begin
         act_ff <= (x_ff < horiz_display_period) & (y_ff < vert_display_period);
         if (fs_ff)
         begin
            addr_ff <= 16'h0000;
         end
         else if (ls_ff & rot_ff[POS_ROT_EN])
         begin
            addr_ff <= addr_ff + {8'h00, stride_ff};
         end
      end
   end
   assign o_line_start     = ls_ff;
   assign o_frame_start    = fs_ff;
   assign o_display_active = act_ff;
   assign o_line_addr      = addr_ff;

   // ==========================================================
   // Checks on the bank's outputs and internal state
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   a_pin_dir_write: assert property (wr && idx == IDX_PDIR
      && !panel_ff[0] |=> o_pin_oe == $past(wdat[4:0]))
      else $error("direction write not seen on enables");
   a_pin_ded: assert property (panel_ff[0]
      |-> o_pin_oe[3:0] == 4'hF && o_pin[3:0] == i_panel_data_upper)
      else $error("shared pin not given to panel");
   a_pin_out_lvl: assert property (dir_ff[0] && !panel_ff[0]
      |-> o_pin[0] == ctl_ff[0])
      else $error("driven level differs from control");
   a_pin_read_in: assert property (req && !i_wb_we && idx == IDX_PLVL
      && dir_ff == 5'h00 |=> o_wb_ack && o_wb_dat[4:0] == $past(sync2_ff))
      else $error("input level not returned");
   a_resv_zero: assert property (o_wb_ack && $past(idx) == IDX_PDIR
      |-> o_wb_dat[7:5] == 3'h0)
      else $error("unused bits not zero");
   a_scr_hold: assert property (!(wr && idx == IDX_SCR)
      |=> $stable(scr_ff))
      else $error("scratch changed without write");
   a_land_pix: assert property (!rot_ff[POS_ROT_EN]
      && !clkcfg_ff[POS_HALVE] |-> o_pix_clk_en)
      else $error("landscape pixel tick missing");
   a_def_div8: assert property (disable iff (!i_resetn || wr)
      rot_ff[7:6] == 2'h2 && csel == 2'h3 && !clkcfg_ff[POS_HALVE]
      && o_pix_clk_en |=> !o_pix_clk_en[*7] ##1 o_pix_clk_en)
      else $error("default divide by eight wrong");
   a_alt_ratio: assert property (rot_ff[7:6] == 2'h3
      && o_pix_clk_en |-> o_mem_clk_en)
      else $error("alternate memory tick missing");
   a_line_len: assert property (ls_ff && !$past(wr)
      |-> $past(x_ff) == $past(htot) - 11'h001)
      else $error("line length wrong");
   a_frame_len: assert property (fs_ff && !$past(wr)
      |-> $past(y_ff) == $past(vtot) - 11'h001)
      else $error("frame height wrong");
   a_stride_step: assert property (ls_ff && !fs_ff && rot_ff[POS_ROT_EN]
      && !wr |=> o_line_addr == $past(addr_ff) + {8'h00, stride_ff})
      else $error("stride step wrong");

   c_alt_mode: cover property (rot_ff[7:6] == 2'h3 && o_pix_clk_en);
   c_frame: cover property (fs_ff);
   c_pin_read: cover property (o_wb_ack && $past(idx) == IDX_PLVL);
   c_dedicated: cover property (panel_ff[0] && dir_ff != 5'h00);
endmodule : grc_regs
